// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic i_core_clk, i_sys_rst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
	logic i_arvalid, o_arready, o_rvalid, i_rready, i_media_present, i_media_cleaning, g;
	logic i_media_gen3, i_write_protect, i_high_capacity, i_blk_buffered, i_blk_on_tape;
	logic o_write_good, o_buffered_mode, o_fixed_block, o_post_err, o_log_exception_report;
	logic o_compression_enable, o_sync_at_early_warning, o_select_compression;
	logic [1:0] o_bresp, o_rresp, o_transfer_disconnect_control, r;
	logic [3:0] i_wstrb;
	logic [7:0] i_awaddr, i_araddr, i_cur_density, o_density_sel;
	logic [15:0] o_max_burst, o_write_delay;
	logic [23:0] o_block_length;
	logic [31:0] i_wdata, o_rdata, d;
	int failures, checks_done, cyc, hdr, tot, n, p, e;
	tpr_responder dut_u (.i_core_clk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_media_present,
		.i_media_cleaning, .i_media_gen3, .i_write_protect, .i_high_capacity, .i_cur_density,
		.i_blk_buffered, .i_blk_on_tape, .o_write_good, .o_buffered_mode, .o_fixed_block,
		.o_block_length, .o_max_burst, .o_transfer_disconnect_control, .o_write_delay,
		.o_post_err, .o_log_exception_report, .o_compression_enable,
		.o_sync_at_early_warning, .o_select_compression, .o_density_sel);
	tpr_host host_u (.i_core_clk, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid),
		.i_awready(o_awready), .o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_wvalid(i_wvalid),
		.i_wready(o_wready), .i_bresp(o_bresp), .i_bvalid(o_bvalid), .o_bready(i_bready),
		.o_araddr(i_araddr), .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rdata(o_rdata),
		.i_rresp(o_rresp), .i_rvalid(o_rvalid), .o_rready(i_rready));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		checks_done++;
		if (y !== x) begin
			failures++;
			$display("BAD %s exp %h got %h", s, x, y);
		end
	endtask : chk
	task automatic report_and_stop();
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		void'($urandom(44060));
		{i_sys_rst, i_media_present, i_media_cleaning, i_media_gen3} = 4'hD;
		{i_write_protect, i_high_capacity, i_blk_buffered, i_blk_on_tape} = 4'h0;
		i_cur_density = 8'h19;
		repeat (10) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		i_write_protect <= 1'($urandom);
		repeat (3) @(posedge i_core_clk);
		d = {o_buffered_mode, o_transfer_disconnect_control, o_post_err, o_log_exception_report,
			o_compression_enable, o_sync_at_early_warning, o_select_compression, o_block_length};
		chk("dflt", 32'h87000000, d);
		chk("dflt2", 32'h008000C8, {o_max_burst, o_write_delay});
		host_u.rd(8'h24, d, r);
		chk("media", {15'h0, i_write_protect, 16'h0083}, d & 32'h1_00FF);
		host_u.rd(8'h40, d, r);
		chk("unmap", tpr_pkg::RESP_SLVERR, r);
		// random words, with all ones second and zero last for the limits at both ends
		for (int i = 0; i < 6; i++) begin
			d = (i == 5) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $urandom;
			i_high_capacity <= i[0];
			host_u.wr(8'h20, d, r);
			host_u.wr(8'h1C, d, r);
			host_u.wr(8'h14, d, r);
			host_u.wr(8'h18, d, r);
			chk("flags", {d[3:0] != 0, d[7:4] != 0, d[11:8] != 0, d[15:12] != 0,
				d[19:16] != 0}, {o_post_err, o_log_exception_report, o_compression_enable,
				o_sync_at_early_warning, o_select_compression});
			p = d[15:0] < 16'h000F ? 16'h000F : d[15:0] > 16'h1964 ? 16'h1964 : d[15:0];
			chk("wdelay", p, o_write_delay);
			p = d[23:16] > 3 ? 3 : d[23:16];
			chk("burst", {p[1:0], d[15:0]}, {o_transfer_disconnect_control, o_max_burst});
			p = i[0] ? 32'hFFFFF : 32'h40000;
			n = d[23:0] > p ? p : d[23:0];
			chk("blklen", {n != 0, n[23:0]}, {o_fixed_block, o_block_length});
		end
		// bad descriptor length dropped whole, then unbuffered
		host_u.wr(8'h10, 32'h00000401, r);
		chk("hresp", tpr_pkg::RESP_OKAY, r);
		host_u.rd(8'h08, d, r);
		chk("selerr", 3, {d[3], o_buffered_mode});
		host_u.wr(8'h08, 32'h8, r);
		host_u.wr(8'h10, 32'h00190800, r);
		host_u.wr(8'h10, 32'h007F0800, r);
		chk("hdr", 9'h019, {o_buffered_mode, o_density_sel});
		for (int k = 0; k < 2; k++) begin
			{i_blk_buffered, i_blk_on_tape} <= k ? 2'b01 : 2'b10;
			@(posedge i_core_clk);
			{i_blk_buffered, i_blk_on_tape} <= 2'b00;
			g = 1'b0;
			repeat (3) begin
				@(posedge i_core_clk);
				g = g | o_write_good;
			end
			chk("wgood", k, g);
		end
		// both forms, descriptor on/off, every page control, random allocation cut short or not
		for (int i = 0; i < 4; i++) begin
			hdr = i[0] ? 8 : 4;
			p = hdr + (i[1] ? 0 : 8);
			tot = p + 8;
			n = $urandom_range(tot + 2, p + 3);
			host_u.wr(8'h04, n, r);
			host_u.wr(8'h00, {15'h0, 6'h0A, i[1:0], i[1], i[0] ? 8'h5A : 8'h1A}, r);
			for (int k = 0; k < tot && k < n; k++) begin
				host_u.rd(8'h0C, d, r);
				e = -1;
				if (k == 0) e = i[0] ? 0 : tot - 1;
				if (k == 1 && i[0]) e = tot - 2;
				if (k == hdr - 1) e = i[1] ? 0 : 8;
				if (k == p) e = 8'h0A;
				if (k == p + 1) e = 8'h06;
				if (k == p + 2) e = i == 1;
				if (e >= 0) chk("byte", e, d[7:0]);
			end
			host_u.rd(8'h08, d, r);
			chk("stat", 2, d[3:0]);
		end
		// empty allocation, vendor page through the short form
		for (int j = 0; j < 2; j++) begin
			host_u.wr(8'h04, j ? 10 : 0, r);
			host_u.wr(8'h00, {15'h0, j ? 6'h3E : 6'h0A, 3'h0, 8'h1A}, r);
			host_u.rd(8'h08, d, r);
			chk("stat0", j ? 6 : 2, d[2:0]);
		end
		report_and_stop();
	end
endmodule : testbench

// *** tpr_host.sv ***
`timescale 1ns/1ps
// host initiator: one write and one read at a time
module tpr_host (
	input wire logic i_core_clk,
	output logic [7:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	output logic o_bready,
	output logic [7:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic o_rready
);
	// idle bus; whole words only
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
		o_wstrb = 4'hF;
	end
	// each channel drops valid at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_core_clk);
		o_awaddr <= a;
		o_wdata <= d;
		{o_awvalid, o_wvalid, o_bready} <= 3'h7;
		do begin
			@(posedge i_core_clk);
			if (i_awready) o_awvalid <= 1'b0;
			if (i_wready) o_wvalid <= 1'b0;
		end while (!i_bvalid);
		o_bready <= 1'b0;
		r = i_bresp;
	endtask : wr
	// read answer taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_core_clk);
		o_araddr <= a;
		{o_arvalid, o_rready} <= 2'h3;
		do begin
			@(posedge i_core_clk);
			if (i_arready) o_arvalid <= 1'b0;
		end while (!i_rvalid);
		o_rready <= 1'b0;
		d = i_rdata;
		r = i_rresp;
	endtask : rd
endmodule : tpr_host

// *** tpr_pkg.sv ***
package tpr_pkg;
	// query opcodes, short and long form
	localparam logic [7:0] OP_SENSE6 = 8'h1A;
	localparam logic [7:0] OP_SENSE10 = 8'h5A;
	// page codes with a special meaning
	localparam logic [5:0] PG_NONE = 6'h00;
	localparam logic [5:0] PG_VEND = 6'h3E;
	localparam logic [5:0] PG_ALL = 6'h3F;
	// page table in ascending code order, lengths exclude the 2-byte page header
	localparam int NPG = 7;
	localparam logic [NPG-1:0][5:0] PG_CODE =
		{6'h3E, 6'h11, 6'h10, 6'h0F, 6'h0A, 6'h02, 6'h01};
	localparam logic [NPG-1:0][7:0] PG_LEN =
		{8'h0F, 8'h06, 8'h0E, 8'h0E, 8'h06, 8'h0E, 8'h0A};
	localparam logic [15:0] PG_HDR = 16'h0002;
	// response framing
	localparam logic [15:0] HDR6 = 16'h0004;
	localparam logic [15:0] HDR10 = 16'h0008;
	localparam logic [7:0] BDL = 8'h08;
	// media type codes
	localparam logic [7:0] MT_NONE = 8'h00;
	localparam logic [7:0] MT_CLEAN = 8'h81;
	localparam logic [7:0] MT_GEN2 = 8'h82;
	localparam logic [7:0] MT_GEN3 = 8'h83;
	// density codes
	localparam logic [7:0] DEN_DEF = 8'h00;
	localparam logic [7:0] DEN_NOP = 8'h7F;
	localparam logic [7:0] DEN_26G = 8'h17;
	localparam logic [7:0] DEN_60G = 8'h18;
	localparam logic [7:0] DEN_10G = 8'h19;
	localparam logic [7:0] DEN_10GN = 8'h80;
	localparam logic [7:0] DEN_20G = 8'h81;
	// limits
	localparam logic [23:0] BLK_MAX_LO = 24'h040000;
	localparam logic [23:0] BLK_MAX_HI = 24'h0FFFFF;
	localparam logic [1:0] TDC_MAX = 2'h3;
	localparam logic [15:0] WD_MIN = 16'h000F;
	localparam logic [15:0] WD_MAX = 16'h1964;
	// constant page content
	localparam logic [7:0] ALG_LZ = 8'h10;
	localparam logic [7:0] BLKID_BIT = 8'h20;
	localparam logic [7:0] EARLY_REC = 8'h08;
	localparam logic [7:0] FMT_AUTO = 8'h01;
	// register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ALLOC = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0C;
	localparam logic [7:0] REG_HDR = 8'h10;
	localparam logic [7:0] REG_BLKLEN = 8'h14;
	localparam logic [7:0] REG_FLAGS = 8'h18;
	localparam logic [7:0] REG_BURST = 8'h1C;
	localparam logic [7:0] REG_WDELAY = 8'h20;
	localparam logic [7:0] REG_MEDIA = 8'h24;
	// field positions
	localparam int CMD_SUP = 8;
	localparam int CMD_PCTL = 9;
	localparam int CMD_PG = 11;
	localparam int ST_SELERR = 3;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {PGCTL_CUR, PGCTL_CHG, PGCTL_DEF, PGCTL_SAVED} tpr_pgctl_e;
	// one set of changeable values; fixed clears constant bits in the mask view
	typedef struct packed {
		logic fixed;
		logic buffered;
		logic post_err;
		logic log_exception_report;
		logic compression_enable;
		logic sync_at_early_warning;
		logic select_compression;
		logic [1:0] transfer_disconnect_control;
		logic [15:0] max_burst;
		logic [15:0] write_delay;
		logic [23:0] block_length;
	} tpr_view_s;
	localparam tpr_view_s VIEW_DEF = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
		2'h0, 16'h0080, 16'h00C8, 24'h000000};
	localparam tpr_view_s VIEW_CHG = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		2'h3, 16'hFFFF, 16'hFFFF, 24'hFFFFFF};
endpackage : tpr_pkg

// *** tpr_responder.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1: round out-of-range values, never descriptor length
// R2: buffered mode defaults one, accepts 0/1
// R3: descriptor length reads eight, accepts 0/8
// R4: block length default zero, capped per mode
// R5: burst size defaults 0080h, any 16-bit
// R6: disconnect control defaults zero, range 0..3
// R7: write delay default C8h, range Fh..1964h
// R8: single-bit settings accept 0/1 with defaults
// R9: accept short 1Ah and long 5Ah forms
// R10: suppress bit omits the block descriptor
// R11: page control picks current/changeable/default/saved
// R12: zero allocation completes good without data
// R13: header, descriptor, then pages, sized per form
// R14: length field counts bytes after itself
// R15: media type none, cleaning, two generations
// R16: write-protect bit mirrors cartridge switch
// R17: buffered mode picks when writes report good
// R18: density reports current, 7Fh keeps, listed select
// R19: zero block length means variable length
// R20: supported page codes, all-pages for queries
// R21: page length excludes its two header bytes
// R22: clamp to nearest limit, store and report
module tpr_responder (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_media_present,
	input wire logic i_media_cleaning,
	input wire logic i_media_gen3,
	input wire logic i_write_protect,
	input wire logic i_high_capacity,
	input wire logic [7:0] i_cur_density,
	input wire logic i_blk_buffered,
	input wire logic i_blk_on_tape,
	output logic o_write_good,
	output logic o_buffered_mode,
	output logic o_fixed_block,
	output logic [23:0] o_block_length,
	output logic [15:0] o_max_burst,
	output logic [1:0] o_transfer_disconnect_control,
	output logic [15:0] o_write_delay,
	output logic o_post_err,
	output logic o_log_exception_report,
	output logic o_compression_enable,
	output logic o_sync_at_early_warning,
	output logic o_select_compression,
	output logic [7:0] o_density_sel
);
	// every flop of the block
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [12:0] pin1; // first sync stage, read only by pin2
		logic [12:0] pin2; // {density, hicap, wp, gen3, clean, present}
		tpr_pkg::tpr_view_s cur; // current settings
		logic fixed_blk;
		logic [7:0] dens_sel;
		logic busy; // response being drained
		logic done;
		logic chk; // command refused
		logic sel_err; // selection refused
		logic [7:0] opcode;
		logic long_cmd;
		logic suppress;
		tpr_pkg::tpr_pgctl_e pgctl;
		logic [5:0] pgcode;
		logic [tpr_pkg::NPG-1:0] pgset;
		logic [15:0] alloc;
		logic [15:0] total; // bytes the full response holds
		logic [15:0] xfer; // bytes actually handed out
		logic [15:0] pos;
		logic wgood;
	} tpr_state_s;

	// reset image of the state
	function automatic tpr_state_s rst_val();
		tpr_state_s r;
		r = '0;
		r.awready = 1'b1;
		r.wready = 1'b1;
		r.arready = 1'b1;
		r.cur = tpr_pkg::VIEW_DEF; // R2 R4 R5 R6 R7 R8
		r.dens_sel = tpr_pkg::DEN_DEF;
		return r;
	endfunction : rst_val

	localparam tpr_state_s ST_RST = rst_val();

	tpr_state_s q;
	tpr_state_s d;

	// decode shared by read and write channels
	function automatic logic is_mapped(logic [7:0] a);
		return a inside {tpr_pkg::REG_CMD, tpr_pkg::REG_ALLOC, tpr_pkg::REG_STAT,
			tpr_pkg::REG_DATA, tpr_pkg::REG_HDR, tpr_pkg::REG_BLKLEN, tpr_pkg::REG_FLAGS,
			tpr_pkg::REG_BURST, tpr_pkg::REG_WDELAY, tpr_pkg::REG_MEDIA};
	endfunction : is_mapped

	// media type from the synced cartridge pins
	function automatic logic [7:0] media_type(logic [12:0] p);
		if (!p[0]) begin
			return tpr_pkg::MT_NONE; // R15
		end
		if (p[1]) begin
			return tpr_pkg::MT_CLEAN; // R15
		end
		return p[2] ? tpr_pkg::MT_GEN3 : tpr_pkg::MT_GEN2; // R15
	endfunction : media_type

	// densities that selection may ask for
	function automatic logic den_ok(logic [7:0] c);
		return c inside {tpr_pkg::DEN_DEF, tpr_pkg::DEN_NOP, tpr_pkg::DEN_26G,
			tpr_pkg::DEN_60G, tpr_pkg::DEN_10G, tpr_pkg::DEN_10GN, tpr_pkg::DEN_20G}; // R18
	endfunction : den_ok

	// register image, also the base for byte-lane merges
	function automatic logic [31:0] readback(tpr_state_s s, logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			tpr_pkg::REG_CMD: r = {15'h0000, s.pgcode, s.pgctl, s.suppress, s.opcode};
			tpr_pkg::REG_ALLOC: r = {16'h0000, s.alloc};
			tpr_pkg::REG_STAT: r = {s.pos, 12'h000, s.sel_err, s.chk, s.done, s.busy};
			tpr_pkg::REG_HDR: r = {8'h00, s.dens_sel, tpr_pkg::BDL, 7'h00, s.cur.buffered};
			tpr_pkg::REG_BLKLEN: r = {8'h00, s.cur.block_length};
			tpr_pkg::REG_FLAGS: r = {15'h0000, s.cur.select_compression,
				3'h0, s.cur.sync_at_early_warning, 3'h0, s.cur.compression_enable,
				3'h0, s.cur.log_exception_report, 3'h0, s.cur.post_err};
			tpr_pkg::REG_BURST: r = {14'h0000, s.cur.transfer_disconnect_control,
				s.cur.max_burst};
			tpr_pkg::REG_WDELAY: r = {16'h0000, s.cur.write_delay};
			tpr_pkg::REG_MEDIA: r = {14'h0000, s.pin2[4], s.pin2[3], s.pin2[12:5],
				media_type(s.pin2)};
			default: r = 32'h0000_0000; // data port and holes read zero
		endcase
		return r;
	endfunction : readback

	// pages a query asks for; vendor page only through the long form
	function automatic logic [tpr_pkg::NPG-1:0] sel_pages(logic [5:0] pg, logic lng);
		logic [tpr_pkg::NPG-1:0] r;
		r = '0;
		for (int i = 0; i < tpr_pkg::NPG; i++) begin
			if ((pg == tpr_pkg::PG_ALL || pg == tpr_pkg::PG_CODE[i])
				&& (lng || tpr_pkg::PG_CODE[i] != tpr_pkg::PG_VEND)) begin
				r[i] = 1'b1; // R9 R20
			end
		end
		return r;
	endfunction : sel_pages

	// bytes taken by the chosen pages
	function automatic logic [15:0] pages_len(logic [tpr_pkg::NPG-1:0] set);
		logic [15:0] n;
		n = 16'h0000;
		for (int i = 0; i < tpr_pkg::NPG; i++) begin
			if (set[i]) begin
				n = n + {8'h00, tpr_pkg::PG_LEN[i]} + tpr_pkg::PG_HDR;
			end
		end
		return n;
	endfunction : pages_len

	// one byte of page i; unlisted bytes read zero, constant bits too in the changeable view
	function automatic logic [7:0] pg_byte(logic [2:0] i, logic [7:0] k, tpr_pkg::tpr_view_s v);
		logic [7:0] f;
		logic [7:0] b;
		f = {8{v.fixed}};
		b = 8'h00;
		if (k == 8'h00) begin
			b = {2'b00, tpr_pkg::PG_CODE[i]}; // savable flag stays clear
		end else if (k == 8'h01) begin
			b = tpr_pkg::PG_LEN[i]; // R21
		end else begin
			case (i)
				3'h0: begin // error recovery
					if (k == 8'h02) b = (tpr_pkg::EARLY_REC & f) | {5'h00, v.post_err, 2'h0};
				end
				3'h1: begin // disconnect/reconnect
					if (k == 8'h0A) b = v.max_burst[15:8];
					if (k == 8'h0B) b = v.max_burst[7:0];
					if (k == 8'h0C) b = {6'h00, v.transfer_disconnect_control};
				end
				3'h2: begin // control
					if (k == 8'h02) b = {7'h00, v.log_exception_report};
				end
				3'h3: begin // compression
					if (k == 8'h02) b = {v.compression_enable, v.fixed, 6'h00};
					if (k == 8'h03) b = {v.fixed, 7'h00};
					if (k == 8'h07 || k == 8'h0B) b = tpr_pkg::ALG_LZ & f;
				end
				3'h4: begin // device configuration
					if (k == 8'h06) b = v.write_delay[15:8];
					if (k == 8'h07) b = v.write_delay[7:0];
					if (k == 8'h08) b = tpr_pkg::BLKID_BIT & f;
					if (k == 8'h0A) b = {4'h0, v.sync_at_early_warning, 3'h0};
					if (k == 8'h0E) b = {7'h00, v.select_compression};
				end
				3'h5: begin // medium partition
					if (k == 8'h07) b = tpr_pkg::FMT_AUTO & f;
				end
				default: b = 8'h00; // vendor page body is not kept here
			endcase
		end
		return b;
	endfunction : pg_byte

	// byte at the drain position: header, descriptor, pages
	function automatic logic [7:0] resp_byte(tpr_state_s s, tpr_pkg::tpr_view_s v);
		logic [15:0] hl;
		logic [15:0] p;
		logic [15:0] st;
		logic [15:0] ln;
		logic [15:0] dlen;
		logic [7:0] mt;
		logic [7:0] dsb;
		logic [7:0] bdl;
		logic [7:0] b;
		hl = s.long_cmd ? tpr_pkg::HDR10 : tpr_pkg::HDR6; // R13
		dlen = s.total - (s.long_cmd ? 16'h0002 : 16'h0001); // R14
		mt = media_type(s.pin2) & {8{v.fixed}};
		dsb = {s.pin2[3] & v.fixed, 2'b00, v.buffered, 4'h0}; // R16
		bdl = s.suppress ? 8'h00 : tpr_pkg::BDL; // R3 R10
		b = 8'h00;
		p = s.pos;
		if (p < hl) begin
			if (!s.long_cmd) begin
				case (p[1:0])
					2'h0: b = dlen[7:0];
					2'h1: b = mt;
					2'h2: b = dsb;
					default: b = bdl;
				endcase
			end else begin
				case (p[2:0])
					3'h0: b = dlen[15:8];
					3'h1: b = dlen[7:0];
					3'h2: b = mt;
					3'h3: b = dsb;
					3'h7: b = bdl;
					default: b = 8'h00;
				endcase
			end
		end else if (!s.suppress && p < hl + 16'h0008) begin
			case (p[2:0] - hl[2:0])
				3'h0: b = v.fixed ? s.pin2[12:5] : 8'hFF; // R18
				3'h5: b = v.block_length[23:16];
				3'h6: b = v.block_length[15:8];
				3'h7: b = v.block_length[7:0];
				default: b = 8'h00; // block count always zero
			endcase
		end else begin
			p = p - hl - {8'h00, bdl};
			st = 16'h0000;
			for (int i = 0; i < tpr_pkg::NPG; i++) begin
				if (s.pgset[i]) begin
					ln = {8'h00, tpr_pkg::PG_LEN[i]} + tpr_pkg::PG_HDR;
					if (p >= st && p < st + ln) begin
						b = pg_byte(3'(i), 8'(p - st), v); // R13
					end
					st = st + ln;
				end
			end
		end
		return b;
	endfunction : resp_byte

	// values shown under the requested page control
	function automatic tpr_pkg::tpr_view_s view_of(tpr_state_s s);
		case (s.pgctl)
			tpr_pkg::PGCTL_CUR: return s.cur; // R11
			tpr_pkg::PGCTL_CHG: return tpr_pkg::VIEW_CHG; // R11
			default: return tpr_pkg::VIEW_DEF; // saving unsupported, saved = default
		endcase
	endfunction : view_of

	// combinational helpers
	logic wr_go;
	logic cmd_go;
	logic rd_data;
	logic [31:0] wm;
	logic [31:0] wv;
	logic [7:0] bnow;
	logic [tpr_pkg::NPG-1:0] nset;
	logic nok;
	logic [15:0] ntotal;
	logic [15:0] nalloc;
	logic [15:0] nxfer;
	logic [23:0] blk_cap;
	logic hdr_bad;

	assign wr_go = !q.awready && !q.wready && !q.bvalid;
	assign cmd_go = wr_go && q.awaddr == tpr_pkg::REG_CMD && !q.busy;
	assign rd_data = q.arready && i_arvalid && i_araddr == tpr_pkg::REG_DATA;
	// byte strobes merge onto the present image
	assign wm = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
	assign wv = (readback(q, q.awaddr) & ~wm) | (q.wdata & wm);
	assign bnow = resp_byte(q, view_of(q));
	assign nset = sel_pages(wv[tpr_pkg::CMD_PG+:6], wv[7:0] == tpr_pkg::OP_SENSE10);
	assign nok = (wv[7:0] == tpr_pkg::OP_SENSE6 || wv[7:0] == tpr_pkg::OP_SENSE10)
		&& (wv[tpr_pkg::CMD_PG+:6] == tpr_pkg::PG_NONE || |nset); // R9 R20
	assign ntotal = (wv[7:0] == tpr_pkg::OP_SENSE10 ? tpr_pkg::HDR10 : tpr_pkg::HDR6)
		+ (wv[tpr_pkg::CMD_SUP] ? 16'h0000 : {8'h00, tpr_pkg::BDL}) + pages_len(nset); // R13
	// short form carries only one allocation byte
	assign nalloc = wv[7:0] == tpr_pkg::OP_SENSE10 ? q.alloc : {8'h00, q.alloc[7:0]};
	assign nxfer = ntotal < nalloc ? ntotal : nalloc;
	assign blk_cap = q.pin2[4] ? tpr_pkg::BLK_MAX_HI : tpr_pkg::BLK_MAX_LO; // R4
	// descriptor length is never rounded, unknown densities are refused
	assign hdr_bad = (wv[15:8] != 8'h00 && wv[15:8] != tpr_pkg::BDL) || !den_ok(wv[23:16]);

	// next-state logic
	always_comb begin
		d = q;
		d.pin1 = {i_cur_density, i_high_capacity, i_write_protect, i_media_gen3,
			i_media_cleaning, i_media_present};
		d.pin2 = q.pin1;
		// good-status point for writes
		d.wgood = q.cur.buffered ? i_blk_buffered : i_blk_on_tape; // R17
		// write address and data, taken in either order
		if (q.awready && i_awvalid) begin
			d.awready = 1'b0;
			d.awaddr = i_awaddr;
		end
		if (q.wready && i_wvalid) begin
			d.wready = 1'b0;
			d.wdata = i_wdata;
			d.wstrb = i_wstrb;
		end
		if (q.bvalid && i_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
		if (wr_go) begin
			d.bvalid = 1'b1;
			d.bresp = is_mapped(q.awaddr) ? tpr_pkg::RESP_OKAY : tpr_pkg::RESP_SLVERR;
			case (q.awaddr)
				tpr_pkg::REG_CMD: begin
					if (q.busy) begin
						d.bresp = tpr_pkg::RESP_SLVERR; // busy: command refused
					end else begin
						d.opcode = wv[7:0];
						d.long_cmd = wv[7:0] == tpr_pkg::OP_SENSE10; // R9
						d.suppress = wv[tpr_pkg::CMD_SUP]; // R10
						d.pgctl = tpr_pkg::tpr_pgctl_e'(wv[tpr_pkg::CMD_PCTL+:2]); // R11
						d.pgcode = wv[tpr_pkg::CMD_PG+:6];
						d.pgset = nset;
						d.total = ntotal;
						d.xfer = nxfer;
						d.pos = 16'h0000;
						d.chk = !nok;
						d.done = !nok || nxfer == 16'h0000; // R12
						d.busy = nok && nxfer != 16'h0000;
					end
				end
				tpr_pkg::REG_ALLOC: d.alloc = wv[15:0];
				tpr_pkg::REG_STAT: begin
					if (q.wstrb[0] && q.wdata[tpr_pkg::ST_SELERR]) begin
						d.sel_err = 1'b0;
					end
				end
				tpr_pkg::REG_HDR: begin
					if (hdr_bad) begin
						d.sel_err = 1'b1; // R1 R3
					end else begin
						d.cur.buffered = wv[7:0] != 8'h00; // R2 R22
						if (wv[23:16] != tpr_pkg::DEN_NOP) begin
							d.dens_sel = wv[23:16]; // R18
						end
					end
				end
				tpr_pkg::REG_BLKLEN: begin
					d.cur.block_length = wv[23:0] > blk_cap ? blk_cap : wv[23:0]; // R4 R22
					d.fixed_blk = wv[23:0] != 24'h000000; // R19
				end
				tpr_pkg::REG_FLAGS: begin
					d.cur.post_err = wv[3:0] != 4'h0; // R8
					d.cur.log_exception_report = wv[7:4] != 4'h0; // R8
					d.cur.compression_enable = wv[11:8] != 4'h0; // R8
					d.cur.sync_at_early_warning = wv[15:12] != 4'h0; // R8
					d.cur.select_compression = wv[19:16] != 4'h0; // R8
				end
				tpr_pkg::REG_BURST: begin
					d.cur.max_burst = wv[15:0]; // R5
					d.cur.transfer_disconnect_control = wv[23:16] > {6'h00, tpr_pkg::TDC_MAX}
						? tpr_pkg::TDC_MAX : wv[17:16]; // R6 R22
				end
				tpr_pkg::REG_WDELAY: begin
					if (wv[15:0] < tpr_pkg::WD_MIN) begin
						d.cur.write_delay = tpr_pkg::WD_MIN; // R7 R22
					end else if (wv[15:0] > tpr_pkg::WD_MAX) begin
						d.cur.write_delay = tpr_pkg::WD_MAX; // R7 R22
					end else begin
						d.cur.write_delay = wv[15:0];
					end
				end
				default: d.bvalid = 1'b1; // read-only and unmapped writes dropped
			endcase
		end
		// read channel; one read under way at a time
		if (q.rvalid && i_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
		if (q.arready && i_arvalid) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = is_mapped(i_araddr) ? tpr_pkg::RESP_OKAY : tpr_pkg::RESP_SLVERR;
			d.rdata = readback(q, i_araddr);
			// reading the data port pops one response byte
			if (rd_data && q.busy) begin
				d.rdata = {24'h000000, bnow};
				d.pos = q.pos + 16'h0001;
				if (q.pos + 16'h0001 == q.xfer) begin
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign o_awready = q.awready;
	assign o_wready = q.wready;
	assign o_bresp = q.bresp;
	assign o_bvalid = q.bvalid;
	assign o_arready = q.arready;
	assign o_rdata = q.rdata;
	assign o_rresp = q.rresp;
	assign o_rvalid = q.rvalid;
	assign o_write_good = q.wgood;
	assign o_buffered_mode = q.cur.buffered;
	assign o_fixed_block = q.fixed_blk;
	assign o_block_length = q.cur.block_length;
	assign o_max_burst = q.cur.max_burst;
	assign o_transfer_disconnect_control = q.cur.transfer_disconnect_control;
	assign o_write_delay = q.cur.write_delay;
	assign o_post_err = q.cur.post_err;
	assign o_log_exception_report = q.cur.log_exception_report;
	assign o_compression_enable = q.cur.compression_enable;
	assign o_sync_at_early_warning = q.cur.sync_at_early_warning;
	assign o_select_compression = q.cur.select_compression;
	assign o_density_sel = q.dens_sel;

	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_start_empty;
		cmd_go && nok && nxfer == 16'h0000;
	endsequence
	sequence s_first_short;
		rd_data && q.busy && !q.long_cmd && q.pos == 16'h0000;
	endsequence
	sequence s_bdl_short;
		rd_data && q.busy && !q.long_cmd && q.pos == 16'h0003;
	endsequence

	a_alloc_zero: assert property (s_start_empty |=> q.done && !q.busy && !q.chk) // R12
		else $error("zero allocation did not end good");
	a_bdl_kept: assert property (wr_go && q.awaddr == tpr_pkg::REG_HDR && hdr_bad // R3
		|=> q.sel_err && $stable(o_buffered_mode))
		else $error("bad descriptor length was taken");
	a_blk_capped: assert property (wr_go && q.awaddr == tpr_pkg::REG_BLKLEN // R4
		|=> o_block_length <= $past(blk_cap) && o_fixed_block == (o_block_length != 0))
		else $error("block length over its cap");
	a_wdelay_range: assert property (wr_go && q.awaddr == tpr_pkg::REG_WDELAY // R7
		|=> o_write_delay >= tpr_pkg::WD_MIN && o_write_delay <= tpr_pkg::WD_MAX)
		else $error("write delay outside its window");
	a_tdc_clamp: assert property (wr_go && q.awaddr == tpr_pkg::REG_BURST // R6
		&& wv[23:16] > 8'h03 |=> o_transfer_disconnect_control == 2'h3)
		else $error("disconnect control not clamped");
	a_write_ack: assert property (!o_buffered_mode && i_blk_on_tape // R17
		|=> o_write_good)
		else $error("unbuffered write not acknowledged");
	a_len_field: assert property (s_first_short |=> o_rvalid // R14
		&& o_rdata[7:0] == $past(q.total[7:0]) - 8'h01)
		else $error("length field wrong");
	a_desc_omit: assert property (s_bdl_short ##0 q.suppress[*1] |=> o_rdata[7:0] == 8'h00) // R10
		else $error("descriptor length shown while suppressed");
	a_flag_clamp: assert property (wr_go && q.awaddr == tpr_pkg::REG_FLAGS // R8
		&& wv[11:8] > 4'h1 |=> o_compression_enable)
		else $error("wide flag value not rounded to one");
endmodule : tpr_responder
